// file: core/ptmr_top.sv
// Overview of operation
// RL1: timer ticks only from instruction clock, core clock divided by four.
// RL2: count and period registers are both eight bits wide.
// RL3: count starts at zero and increments each prescaled tick while running.
// RL4: prescale select 00 divides by 1, 01 by 4, 1x by 16.
// RL5: count is compared with period every cycle; equality on a prescaled tick gives match.
// RL6: after match count reloads zero and postscaler advances.
// RL7: software reads count and period at any time and writes them while the module disable bit is clear.
// RL8: reset clears count and sets period to all ones.
// RL9: count write, control write and reset clear prescaler and postscaler.
// RL10: control write leaves the count value unchanged.
// RL11: postscale select picks 1 to 16 matches per interrupt flag.
// RL12: postscaled match latches flag; enable gates request; priority bit selects level.
// RL13: run bit at position 2 starts and stops the timer.
// RL14: unscaled match pulse is provided as time base for pwm units.
// RL15: serial port mode 0011 takes the match pulse as shift clock.
// RL16: in sleep the timer stops and count and period hold.
// RL17: module disable bit holds the timer in reset without clock.
// RL18: postscaler wraps to zero at the selected ratio.
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_regs.svh"

module ptmr_top
	import ptmr_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic AWVALID_I,
	input wire logic [31:0] AWADDR_I,
	output logic AWREADY_O,
	input wire logic WVALID_I,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	output logic WREADY_O,
	output logic BVALID_O,
	output logic [1:0] BRESP_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic [31:0] ARADDR_I,
	output logic ARREADY_O,
	output logic RVALID_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	input wire logic RREADY_I,
	input wire logic SLEEP_I,
	input wire logic [3:0] SSP_MODE_SEL_I,
	output logic MATCH_O,
	output logic SSP_SHIFT_CLK_O,
	output logic IRQ_O,
	output logic IRQ_PRIO_O
);

	// **********************************************
	// bus write channel
	// **********************************************
	logic awready_q;
	logic awready_d;
	logic wready_q;
	logic wready_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic aw_hold_q;
	logic aw_hold_d;
	logic w_hold_q;
	logic w_hold_d;
	ptmr_wreq_s wreq_q;
	logic aw_take_w;
	logic w_take_w;
	logic wr_fire_w;
	logic wr_hit_w;

	assign aw_take_w = AWVALID_I & awready_q;
	assign w_take_w = WVALID_I & wready_q;
	// address and data may arrive in either order; both are parked
	assign wr_fire_w = aw_hold_q & w_hold_q & !bvalid_q;
	assign aw_hold_d = wr_fire_w ? 1'b0 : (aw_hold_q | aw_take_w);
	assign w_hold_d = wr_fire_w ? 1'b0 : (w_hold_q | w_take_w);
	assign bvalid_d = wr_fire_w | (bvalid_q & !BREADY_I);
	assign awready_d = !aw_hold_d & !bvalid_d;
	assign wready_d = !w_hold_d & !bvalid_d;

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
		end else begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			wreq_q <= '0;
			bresp_q <= `PTMR_RESP_OKAY;
		end else begin
			if (aw_take_w) begin
				wreq_q.addr <= AWADDR_I[7:0];
			end
			if (w_take_w) begin
				wreq_q.data <= WDATA_I[7:0];
				wreq_q.strb <= WSTRB_I[0];
			end
			if (wr_fire_w) begin
				bresp_q <= wr_hit_w ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
			end
		end
	end

	// **********************************************
	// write decode
	// **********************************************
	logic sel_count_w;
	logic sel_period_w;
	logic sel_ctrl_w;
	logic sel_flag_w;
	logic sel_en_w;
	logic sel_prio_w;
	logic sel_dis_w;
	logic wr_ok_w;
	logic wr_count_w;
	logic wr_period_w;
	logic wr_ctrl_w;
	logic wr_flag_w;
	logic wr_en_w;
	logic wr_prio_w;
	logic wr_dis_w;

	assign sel_count_w = (wreq_q.addr == `PTMR_OFS_COUNT);
	assign sel_period_w = (wreq_q.addr == `PTMR_OFS_PERIOD);
	assign sel_ctrl_w = (wreq_q.addr == `PTMR_OFS_CTRL);
	assign sel_flag_w = (wreq_q.addr == `PTMR_OFS_IRQ_FLAG);
	assign sel_en_w = (wreq_q.addr == `PTMR_OFS_IRQ_EN);
	assign sel_prio_w = (wreq_q.addr == `PTMR_OFS_IRQ_PRIO);
	assign sel_dis_w = (wreq_q.addr == `PTMR_OFS_DISABLE);
	assign wr_hit_w = sel_count_w | sel_period_w | sel_ctrl_w | sel_flag_w |
		sel_en_w | sel_prio_w | sel_dis_w;
	assign wr_ok_w = wr_fire_w & wreq_q.strb;
	assign wr_count_w = wr_ok_w & sel_count_w;
	assign wr_period_w = wr_ok_w & sel_period_w;
	assign wr_ctrl_w = wr_ok_w & sel_ctrl_w;
	assign wr_flag_w = wr_ok_w & sel_flag_w;
	assign wr_en_w = wr_ok_w & sel_en_w;
	assign wr_prio_w = wr_ok_w & sel_prio_w;
	assign wr_dis_w = wr_ok_w & sel_dis_w;

	// **********************************************
	// configuration registers
	// **********************************************
	ptmr_ctrl_s ctrl_q;
	logic [7:0] period_q; // RL2
	logic irq_en_q;
	logic irq_prio_q;
	logic disable_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			disable_q <= 1'b0;
			irq_en_q <= 1'b0;
			irq_prio_q <= 1'b0;
		end else begin
			if (wr_dis_w) begin
				disable_q <= wreq_q.data[0];
			end
			if (wr_en_w) begin
				irq_en_q <= wreq_q.data[0];
			end
			if (wr_prio_w) begin
				irq_prio_q <= wreq_q.data[0];
			end
		end
	end

	// a disabled timer behaves as if reset; control, period and count writes are dropped
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || disable_q) begin // RL17
			ctrl_q <= ptmr_ctrl_s'(`PTMR_RST_CTRL);
			period_q <= `PTMR_RST_PERIOD; // RL8
		end else begin
			if (wr_ctrl_w) begin
				ctrl_q <= ptmr_ctrl_s'(wreq_q.data[6:0]);
			end
			if (wr_period_w) begin
				period_q <= wreq_q.data; // RL7
			end
		end
	end

	// **********************************************
	// instruction clock and prescaler
	// **********************************************
	logic [1:0] instr_div_q;
	logic instr_ce_w;
	logic tick_w;
	logic scaler_clr_w;
	logic presc_ce_w;

	assign instr_ce_w = (instr_div_q == `PTMR_INSTR_DIV); // RL1

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			instr_div_q <= 2'h0;
		end else begin
			instr_div_q <= instr_div_q + 2'h1;
		end
	end

	// sleep and disable stop the ticks; in sleep count and period simply hold, disable resets them
	assign tick_w = instr_ce_w & ctrl_q.run & !SLEEP_I & !disable_q; // RL13 RL16
	assign scaler_clr_w = wr_count_w | wr_ctrl_w | disable_q; // RL9 RL10

	ptmr_presc u_presc (
		.clk_i(CORE_CLK_I),
		.rst_i(RST_I),
		.clr_i(scaler_clr_w),
		.tick_i(tick_w),
		.sel_i(ctrl_q.presc_sel),
		.ce_o(presc_ce_w)
	);

	// **********************************************
	// count, compare and postscaler
	// **********************************************
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic equal_w;
	logic match_w;
	logic [3:0] post_q;
	logic [3:0] post_d;
	logic post_wrap_w;
	logic flag_set_w;

	assign equal_w = (count_q == period_q); // RL5
	assign match_w = presc_ce_w & equal_w;
	// software write beats a concurrent increment
	assign count_d = wr_count_w ? wreq_q.data : // RL7
		match_w ? `PTMR_RST_COUNT : // RL6
		presc_ce_w ? count_q + 8'h01 : count_q; // RL3

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || disable_q) begin
			count_q <= `PTMR_RST_COUNT; // RL8
		end else begin
			count_q <= count_d;
		end
	end

	assign post_wrap_w = (post_q == ctrl_q.post_sel); // RL11
	assign flag_set_w = match_w & post_wrap_w;
	assign post_d = scaler_clr_w ? 4'h0 :
		!match_w ? post_q : // RL6
		post_wrap_w ? 4'h0 : post_q + 4'h1; // RL18

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			post_q <= 4'h0;
		end else begin
			post_q <= post_d;
		end
	end

	// **********************************************
	// interrupt flag
	// **********************************************
	logic flag_q;
	logic flag_d;

	// a new event in the clearing cycle keeps the flag set
	assign flag_d = flag_set_w | (flag_q & !(wr_flag_w & wreq_q.data[0]));

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d; // RL12
		end
	end

	// **********************************************
	// outputs
	// **********************************************
	logic match_out_q;
	logic ssp_clk_q;
	logic irq_q;
	logic prio_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			match_out_q <= 1'b0;
			ssp_clk_q <= 1'b0;
			irq_q <= 1'b0;
			prio_q <= 1'b0;
		end else begin
			match_out_q <= match_w; // RL14
			ssp_clk_q <= match_w & (SSP_MODE_SEL_I == `PTMR_SSP_TMR_CLK); // RL15
			irq_q <= flag_d & irq_en_q; // RL12
			prio_q <= irq_prio_q; // RL12
		end
	end

	// **********************************************
	// bus read channel
	// **********************************************
	logic arready_q;
	logic arready_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic ar_take_w;
	logic [7:0] raddr_w;
	logic [7:0] rmux_w;
	logic rhit_w;

	assign ar_take_w = ARVALID_I & arready_q;
	assign rvalid_d = ar_take_w | (rvalid_q & !RREADY_I);
	assign arready_d = !rvalid_d;
	assign raddr_w = ARADDR_I[7:0];
	assign rhit_w = (raddr_w == `PTMR_OFS_COUNT) |
		(raddr_w == `PTMR_OFS_PERIOD) | (raddr_w == `PTMR_OFS_CTRL) |
		(raddr_w == `PTMR_OFS_IRQ_FLAG) | (raddr_w == `PTMR_OFS_IRQ_EN) |
		(raddr_w == `PTMR_OFS_IRQ_PRIO) | (raddr_w == `PTMR_OFS_DISABLE);
	// bit 7 of the control register is unimplemented and reads zero
	assign rmux_w = (raddr_w == `PTMR_OFS_COUNT) ? count_q :
		(raddr_w == `PTMR_OFS_PERIOD) ? period_q :
		(raddr_w == `PTMR_OFS_CTRL) ? {1'b0, ctrl_q} :
		(raddr_w == `PTMR_OFS_IRQ_FLAG) ? {7'h00, flag_q} :
		(raddr_w == `PTMR_OFS_IRQ_EN) ? {7'h00, irq_en_q} :
		(raddr_w == `PTMR_OFS_IRQ_PRIO) ? {7'h00, irq_prio_q} :
		(raddr_w == `PTMR_OFS_DISABLE) ? {7'h00, disable_q} : 8'h00;

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `PTMR_RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			if (ar_take_w) begin
				rdata_q <= {24'h00_0000, rmux_w};
				rresp_q <= rhit_w ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
			end
		end
	end

	assign AWREADY_O = awready_q;
	assign WREADY_O = wready_q;
	assign BVALID_O = bvalid_q;
	assign BRESP_O = bresp_q;
	assign ARREADY_O = arready_q;
	assign RVALID_O = rvalid_q;
	assign RDATA_O = rdata_q;
	assign RRESP_O = rresp_q;
	assign MATCH_O = match_out_q;
	assign SSP_SHIFT_CLK_O = ssp_clk_q;
	assign IRQ_O = irq_q;
	assign IRQ_PRIO_O = prio_q;

endmodule : ptmr_top
`default_nettype wire

// file: shared/ptmr_regs.svh
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH

// register byte addresses
`define PTMR_OFS_COUNT 8'h00
`define PTMR_OFS_PERIOD 8'h04
`define PTMR_OFS_CTRL 8'h08
`define PTMR_OFS_IRQ_FLAG 8'h0C
`define PTMR_OFS_IRQ_EN 8'h10
`define PTMR_OFS_IRQ_PRIO 8'h14
`define PTMR_OFS_DISABLE 8'h18

// timer_control field positions
`define PTMR_CTRL_PRESC_LSB 0
`define PTMR_CTRL_PRESC_MSB 1
`define PTMR_CTRL_RUN_BIT 2
`define PTMR_CTRL_POST_LSB 3
`define PTMR_CTRL_POST_MSB 6

// reset values
`define PTMR_RST_COUNT 8'h00
`define PTMR_RST_PERIOD 8'hFF
`define PTMR_RST_CTRL 7'h00

// timing: instruction clock is the core clock divided by four
`define PTMR_INSTR_DIV 2'h3
`define PTMR_PRESC_DIV1 4'h0
`define PTMR_PRESC_DIV4 4'h3
`define PTMR_PRESC_DIV16 4'hF

// serial port mode that takes the match as shift clock
`define PTMR_SSP_TMR_CLK 4'h3

// axi responses
`define PTMR_RESP_OKAY 2'h0
`define PTMR_RESP_SLVERR 2'h2

`endif

// file: shared/ptmr_pkg.sv
`default_nettype none
package ptmr_pkg;

	typedef enum logic [1:0] {
		PTMR_PRESC_1,
		PTMR_PRESC_4,
		PTMR_PRESC_16A,
		PTMR_PRESC_16B
	} ptmr_presc_e;

	typedef struct packed {
		logic [3:0] post_sel;
		logic run;
		ptmr_presc_e presc_sel;
	} ptmr_ctrl_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic strb;
	} ptmr_wreq_s;

endpackage : ptmr_pkg
`default_nettype wire

// file: core/ptmr_presc.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_regs.svh"

module ptmr_presc
	import ptmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic tick_i,
	input wire ptmr_presc_e sel_i,
	output logic ce_o
);

	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] limit_w;
	logic wrap_w;

	// **********************************************
	// division select
	// **********************************************
	assign limit_w = (sel_i == PTMR_PRESC_1) ? `PTMR_PRESC_DIV1 :
		(sel_i == PTMR_PRESC_4) ? `PTMR_PRESC_DIV4 :
		`PTMR_PRESC_DIV16; // RL4
	assign wrap_w = (cnt_q >= limit_w);
	assign ce_o = tick_i & wrap_w;
	assign cnt_d = clr_i ? 4'h0 :
		!tick_i ? cnt_q :
		wrap_w ? 4'h0 : cnt_q + 4'h1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule : ptmr_presc
`default_nettype wire

// file: verification/ptmr_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ptmr_props (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic WVALID_I,
	input wire logic WREADY_O,
	input wire logic BVALID_O,
	input wire logic [1:0] BRESP_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic RVALID_O,
	input wire logic [31:0] RDATA_O,
	input wire logic RREADY_I,
	input wire logic SLEEP_I,
	input wire logic MATCH_O,
	input wire logic SSP_SHIFT_CLK_O
);
	// ******
	// timer and bus checks
	// ******
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wr_taken;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence s_rd_taken;
		ARVALID_I && ARREADY_O;
	endsequence
	chk_match_gap: assert property (MATCH_O |=> !MATCH_O [*3])
		else $error("match pulses too close");
	chk_shift_clk: assert property (SSP_SHIFT_CLK_O |-> MATCH_O)
		else $error("shift clock without match");
	chk_sleep_still: assert property (SLEEP_I [*3] |=> !MATCH_O)
		else $error("match while asleep");
	chk_rd_width: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0)
		else $error("read data wider than a byte");
	chk_wr_answer: assert property (s_wr_taken |-> ##[1:2] BVALID_O)
		else $error("write response late");
	chk_rd_answer: assert property (s_rd_taken |=> RVALID_O)
		else $error("read data late");
	chk_b_stands: assert property (BVALID_O && !BREADY_I |=>
		BVALID_O && $stable(BRESP_O)) else $error("write response dropped");
	chk_r_stands: assert property (RVALID_O && !RREADY_I |=>
		RVALID_O && $stable(RDATA_O)) else $error("read data dropped");
endmodule : ptmr_props
bind ptmr_top ptmr_props u_props (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
	.AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I),
	.WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BRESP_O(BRESP_O),
	.BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
	.RVALID_O(RVALID_O), .RDATA_O(RDATA_O), .RREADY_I(RREADY_I),
	.SLEEP_I(SLEEP_I), .MATCH_O(MATCH_O), .SSP_SHIFT_CLK_O(SSP_SHIFT_CLK_O));
`default_nettype wire

// file: verification/period_timer_8bit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_regs.svh"
module period_timer_8bit_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic slp = 1'b0;
	logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, v, sv;
	logic [3:0] ssp = 4'h0;
	logic awr, wrd, bv, arr, rv, mt, sc, irq, pri;
	logic [1:0] br, rr, r;
	logic [31:0] rdv;
	int fail_count = 0;
	int n_checks = 0;
	int n, i, k, p;
	always #10 clk = ~clk;
	ptmr_top dut (.CORE_CLK_I(clk), .RST_I(rst), .AWVALID_I(awv),
		.AWADDR_I(awa), .AWREADY_O(awr), .WVALID_I(wv), .WDATA_I(wd),
		.WSTRB_I(4'hF), .WREADY_O(wrd), .BVALID_O(bv), .BRESP_O(br),
		.BREADY_I(bry), .ARVALID_I(arv), .ARADDR_I(ara), .ARREADY_O(arr),
		.RVALID_O(rv), .RDATA_O(rdv), .RRESP_O(rr), .RREADY_I(rry),
		.SLEEP_I(slp), .SSP_MODE_SEL_I(ssp), .MATCH_O(mt),
		.SSP_SHIFT_CLK_O(sc), .IRQ_O(irq), .IRQ_PRIO_O(pri));
	// ******
	// helpers
	// ******
	task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", s, e, seen);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// a wait that runs out is a mismatch and ends the run
	task timeout;
		fail_count++;
		conclude;
	endtask : timeout
	// ready is raised only after valid, so the response must stand
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int j;
		@(posedge clk);
		if (w) begin
			awv <= 1'b1;
			wv <= 1'b1;
			awa <= {24'h0, a};
			wd <= d;
		end else begin
			arv <= 1'b1;
			ara <= {24'h0, a};
		end
		for (j = 0; j < 50; j++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (arr) arv <= 1'b0;
			if (w ? bv && bry : rv && rry) break;
			if (w && bv) bry <= 1'b1;
			if (!w && rv) rry <= 1'b1;
		end
		r = w ? br : rr;
		v = rdv;
		bry <= 1'b0;
		rry <= 1'b0;
		if (j == 50) timeout;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// cycles between two match pulses
	task gap;
		for (n = 0; n < 400 && !mt; n++) @(posedge clk);
		if (!mt) timeout;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!mt && n < 400);
		if (!mt) timeout;
		chk("shift clk", sc, ssp == 4'h3);
	endtask : gap
	// ******
	// main sequence
	// ******
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(`PTMR_OFS_COUNT);
		chk("count rst", v, 32'h0);
		rd(`PTMR_OFS_PERIOD);
		chk("period rst", v, 32'hFF);
		rd(`PTMR_OFS_CTRL);
		chk("ctrl rst", v, 32'h0);
		wr(`PTMR_OFS_PERIOD, 32'h1A5);
		rd(`PTMR_OFS_PERIOD);
		chk("period rw", v, 32'hA5);
		wr(8'h40, 32'h1);
		chk("unmapped wr", r, 2'h2);
		rd(8'h40);
		chk("unmapped rresp", r, 2'h2);
		chk("unmapped rd", v, 32'h0);
		wr(`PTMR_OFS_PERIOD, 32'h2);
		for (k = 0; k < 4; k++) begin
			ssp <= k[3:0];
			wr(`PTMR_OFS_CTRL, k | 4);
			gap;
			chk("period gap", n, k == 0 ? 12 : k == 1 ? 48 : 192);
		end
		ssp <= 4'h0;
		wr(`PTMR_OFS_PERIOD, 32'h1);
		wr(`PTMR_OFS_IRQ_EN, 32'h1);
		for (k = 0; k < 3; k++) begin
			p = (k == 0) ? 0 : (k == 1) ? 3 : 15;
			wr(`PTMR_OFS_CTRL, 32'h0);
			wr(`PTMR_OFS_COUNT, 32'h0);
			wr(`PTMR_OFS_IRQ_FLAG, 32'h1);
			wr(`PTMR_OFS_CTRL, (p << 3) | 4);
			n = 0;
			for (i = 0; i < 300 && !irq; i++) begin
				@(posedge clk);
				if (mt) n++;
			end
			if (!irq) timeout;
			chk("post count", n, p + 1);
		end
		wr(`PTMR_OFS_CTRL, 32'h0);
		wr(`PTMR_OFS_IRQ_EN, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq masked", irq, 1'b0);
		rd(`PTMR_OFS_IRQ_FLAG);
		chk("flag sticky", v, 32'h1);
		wr(`PTMR_OFS_IRQ_EN, 32'h1);
		wr(`PTMR_OFS_IRQ_PRIO, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq pend", {irq, pri}, 2'h3);
		wr(`PTMR_OFS_IRQ_FLAG, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq clr", irq, 1'b0);
		wr(`PTMR_OFS_COUNT, 32'h77);
		wr(`PTMR_OFS_CTRL, 32'hF9);
		rd(`PTMR_OFS_CTRL);
		chk("ctrl rw", v, 32'h79);
		rd(`PTMR_OFS_COUNT);
		chk("count kept", v, 32'h77);
		wr(`PTMR_OFS_PERIOD, 32'hFF);
		slp <= 1'b1;
		wr(`PTMR_OFS_CTRL, 32'h4);
		rd(`PTMR_OFS_COUNT);
		sv = v;
		repeat (40) @(posedge clk);
		rd(`PTMR_OFS_COUNT);
		chk("sleep hold", v, sv);
		slp <= 1'b0;
		wr(`PTMR_OFS_DISABLE, 32'h1);
		wr(`PTMR_OFS_PERIOD, 32'h10);
		rd(`PTMR_OFS_PERIOD);
		chk("off period", v, 32'hFF);
		rd(`PTMR_OFS_COUNT);
		chk("off count", v, 32'h0);
		wr(`PTMR_OFS_DISABLE, 32'h0);
		// a second reset in mid-run must restore the reset values
		wr(`PTMR_OFS_PERIOD, 32'h10);
		wr(`PTMR_OFS_COUNT, 32'h33);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(`PTMR_OFS_PERIOD);
		chk("rerst period", v, 32'hFF);
		rd(`PTMR_OFS_COUNT);
		chk("rerst count", v, 32'h0);
		conclude;
	end
endmodule : period_timer_8bit_bench
`default_nettype wire
